// ---- timer8_counter_compare_unit.sv ----
// Purpose: 8-bit up/down timer with one compare channel and pin override
// Assumes: register master on clk; tick pin asynchronous; port data same clock
// Notes: tick sources are 1, 8, 64, 256, 1024 or an edge of the tick pin
`default_nettype none
`timescale 1ns/1ps
module timer8_counter_compare_unit (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire timer8_pkg::bus_req_t bus_req,
   output logic [7:0] rdata_r,
   // interrupt requests and service acknowledges
   input wire logic compare_irq_ack,
   input wire logic overflow_irq_ack,
   output logic compare_irq_r,
   output logic overflow_irq_r,
   // external tick pin
   input wire logic ext_tick_pin,
   // pin sharing with the general port
   input wire logic port_out_value,
   input wire logic compare_pin_direction,
   output logic pin_out_r,
   output logic pin_oe_r
);
   timer8_pkg::timer_control_t timer_control_reg_r;
   timer8_pkg::count_dir_t dir_r, dir_nxt;
   logic [7:0] timer_count_value_r, count_nxt;
   logic [7:0] compare_value_r, compare_buf_r;
   logic [9:0] presc_r;
   logic [2:0] ext_sync_r;
   logic block_r, compare_irq_enable_r, overflow_irq_enable_r;
   logic overflow_flag_r, compare_match_flag_r, compare_output_state_r;
   logic tick, match, hit, top_max, bottom, pwm_mode, ovf_evt, ocr_load;
   logic ctrl_wr, count_wr, cmp_wr, mask_wr, flags_wr, force_act, out_nxt;
   timer8_pkg::wave_mode_t mode;
   logic [1:0] act;
   timer8_pkg::timer_control_t ctrl_wdata;

   // address decode shared by all write paths
   function automatic logic wr_at(input timer8_pkg::bus_req_t r, input logic [2:0] a);
      wr_at = r.we && (r.addr == a);
   endfunction

   // tick selection; pin edges come from the synchronised stages only
   function automatic logic tick_sel(input logic [2:0] cs, input logic [9:0] p, input logic rise,
                                     input logic fall);
      unique case (cs)
         3'h0: tick_sel = 1'b0;
         3'h1: tick_sel = 1'b1;
         3'h2: tick_sel = (p & timer8_pkg::PRESC_MASK_8) == timer8_pkg::PRESC_RESET;
         3'h3: tick_sel = (p & timer8_pkg::PRESC_MASK_64) == timer8_pkg::PRESC_RESET;
         3'h4: tick_sel = (p & timer8_pkg::PRESC_MASK_256) == timer8_pkg::PRESC_RESET;
         3'h5: tick_sel = (p & timer8_pkg::PRESC_MASK_1024) == timer8_pkg::PRESC_RESET;
         3'h6: tick_sel = fall;
         3'h7: tick_sel = rise;
      endcase
   endfunction

   assign ctrl_wr = wr_at(bus_req, timer8_pkg::ADDR_CTRL);
   assign count_wr = wr_at(bus_req, timer8_pkg::ADDR_COUNT);
   assign cmp_wr = wr_at(bus_req, timer8_pkg::ADDR_COMPARE);
   assign mask_wr = wr_at(bus_req, timer8_pkg::ADDR_MASK);
   assign flags_wr = wr_at(bus_req, timer8_pkg::ADDR_FLAGS);
   assign ctrl_wdata = bus_req.wdata;

   assign mode = timer_control_reg_r.waveform_mode_bits;
   assign act = timer_control_reg_r.output_action_bits;
   assign pwm_mode = (mode == timer8_pkg::MODE_PHASE_PWM) || (mode == timer8_pkg::MODE_FAST_PWM);
   assign top_max = timer_count_value_r == timer8_pkg::COUNT_MAX;
   assign bottom = timer_count_value_r == timer8_pkg::COUNT_BOTTOM;
   assign match = timer_count_value_r == compare_value_r;
   assign tick = tick_sel(timer_control_reg_r.clock_source_select, presc_r, ext_sync_r[1] & ~ext_sync_r[2],
                          ~ext_sync_r[1] & ext_sync_r[2]);
   assign hit = tick && match && !block_r;
   // force only in non-PWM modes; taken straight from the write, never stored
   assign force_act = ctrl_wr && ctrl_wdata.force_compare_strobe && !pwm_mode;
   // active compare loads at top in phase PWM, at the wrap in fast PWM
   assign ocr_load = pwm_mode && tick && !count_wr && top_max && (dir_r == timer8_pkg::DIR_UP);

   // free running prescaler
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         presc_r <= timer8_pkg::PRESC_RESET;
      else
         presc_r <= presc_r + 10'h001;
   end

   // tick pin synchroniser; stage 0 feeds stage 1 only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ext_sync_r <= 3'h0;
      else
         ext_sync_r <= {ext_sync_r[1:0], ext_tick_pin};
   end

   // count sequence per mode
   always_comb
   begin
      count_nxt = timer_count_value_r;
      dir_nxt = dir_r;
      ovf_evt = 1'b0;
      if (tick)
      begin
         unique case (mode)
            timer8_pkg::MODE_NORMAL:
            begin
               count_nxt = timer_count_value_r + 8'h01;
               ovf_evt = top_max;
            end
            timer8_pkg::MODE_CTC:
            begin
               count_nxt = (match && !block_r) ? timer8_pkg::COUNT_BOTTOM : timer_count_value_r + 8'h01;
               ovf_evt = top_max;
            end
            timer8_pkg::MODE_FAST_PWM:
            begin
               count_nxt = timer_count_value_r + 8'h01;
               ovf_evt = top_max;
            end
            timer8_pkg::MODE_PHASE_PWM:
            begin
               if (dir_r == timer8_pkg::DIR_UP)
               begin
                  dir_nxt = top_max ? timer8_pkg::DIR_DOWN : timer8_pkg::DIR_UP;
                  count_nxt = top_max ? timer_count_value_r - 8'h01 : timer_count_value_r + 8'h01;
               end
               else
               begin
                  dir_nxt = bottom ? timer8_pkg::DIR_UP : timer8_pkg::DIR_DOWN;
                  count_nxt = bottom ? timer_count_value_r + 8'h01 : timer_count_value_r - 8'h01;
                  ovf_evt = bottom;
               end
            end
         endcase
      end
      // cpu write overrides any hardware step
      if (count_wr)
      begin
         count_nxt = bus_req.wdata;
         dir_nxt = dir_r;
         ovf_evt = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         timer_count_value_r <= timer8_pkg::BYTE_RESET;
         dir_r <= timer8_pkg::DIR_UP;
      end
      else
      begin
         timer_count_value_r <= count_nxt;
         dir_r <= dir_nxt;
      end
   end

   // match blocking after a counter write, held until a tick consumes it
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         block_r <= 1'b0;
      else if (count_wr)
         block_r <= 1'b1;
      else if (tick)
         block_r <= 1'b0;
   end

   // control register; force bit is not kept
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         timer_control_reg_r <= '0;
      else if (ctrl_wr)
      begin
         timer_control_reg_r <= bus_req.wdata;
         timer_control_reg_r.force_compare_strobe <= 1'b0;
      end
   end

   // compare value: buffer in PWM modes, direct otherwise
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         compare_value_r <= timer8_pkg::BYTE_RESET;
         compare_buf_r <= timer8_pkg::BYTE_RESET;
      end
      else
      begin
         if (cmp_wr)
            compare_buf_r <= bus_req.wdata;
         if (cmp_wr && !pwm_mode)
            compare_value_r <= bus_req.wdata;
         else if (ocr_load)
            compare_value_r <= compare_buf_r;
      end
   end

   // output state; action bits read live, so a new setting acts at once
   always_comb
   begin
      out_nxt = compare_output_state_r;
      if (!pwm_mode && (hit || force_act))
      begin
         // a force obeys the action bits written beside it, else the stored ones
         unique case (force_act ? ctrl_wdata.output_action_bits : act)
            timer8_pkg::ACT_NONE: out_nxt = compare_output_state_r;
            timer8_pkg::ACT_TOGGLE: out_nxt = !compare_output_state_r;
            timer8_pkg::ACT_CLEAR: out_nxt = 1'b0;
            timer8_pkg::ACT_SET: out_nxt = 1'b1;
         endcase
      end
      else if (mode == timer8_pkg::MODE_FAST_PWM)
      begin
         // compare at max would fight the wrap action; match wins for a flat output
         if (hit && act == timer8_pkg::ACT_TOGGLE)
            out_nxt = !compare_output_state_r;
         else if (hit && act[1])
            out_nxt = act[0];
         else if (tick && top_max && act[1] && compare_value_r != timer8_pkg::COUNT_MAX)
            out_nxt = !act[0];
      end
      else if (mode == timer8_pkg::MODE_PHASE_PWM && hit && act[1])
         out_nxt = (dir_r == timer8_pkg::DIR_UP) ? act[0] : !act[0];
   end

   // mode changes never touch the output state
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         compare_output_state_r <= 1'b0;
      else
         compare_output_state_r <= out_nxt;
   end

   // interrupt enables
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         overflow_irq_enable_r <= 1'b0;
         compare_irq_enable_r <= 1'b0;
      end
      else if (mask_wr)
      begin
         overflow_irq_enable_r <= bus_req.wdata[timer8_pkg::BIT_OVF];
         compare_irq_enable_r <= bus_req.wdata[timer8_pkg::BIT_CMP];
      end
   end

   // sticky flags; a set in the clearing cycle wins
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         overflow_flag_r <= 1'b0;
         compare_match_flag_r <= 1'b0;
      end
      else
      begin
         if (ovf_evt)
            overflow_flag_r <= 1'b1;
         else if (overflow_irq_ack || (flags_wr && bus_req.wdata[timer8_pkg::BIT_OVF]))
            overflow_flag_r <= 1'b0;
         if (hit)
            compare_match_flag_r <= 1'b1;
         else if (compare_irq_ack || (flags_wr && bus_req.wdata[timer8_pkg::BIT_CMP]))
            compare_match_flag_r <= 1'b0;
      end
   end

   // interrupt requests, one cycle behind the flags
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         compare_irq_r <= 1'b0;
         overflow_irq_r <= 1'b0;
      end
      else
      begin
         compare_irq_r <= compare_match_flag_r && compare_irq_enable_r;
         overflow_irq_r <= overflow_flag_r && overflow_irq_enable_r;
      end
   end

   // pin mux; direction always from the port bit
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pin_out_r <= 1'b0;
         pin_oe_r <= 1'b0;
      end
      else
      begin
         pin_out_r <= (act != timer8_pkg::ACT_NONE) ? compare_output_state_r : port_out_value;
         pin_oe_r <= compare_pin_direction;
      end
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata_r <= timer8_pkg::BYTE_RESET;
      else if (!bus_req.re)
         rdata_r <= timer8_pkg::BYTE_RESET;
      else
      begin
         unique case (bus_req.addr)
            timer8_pkg::ADDR_CTRL: rdata_r <= timer_control_reg_r;
            timer8_pkg::ADDR_COUNT: rdata_r <= timer_count_value_r;
            timer8_pkg::ADDR_COMPARE: rdata_r <= pwm_mode ? compare_buf_r : compare_value_r;
            timer8_pkg::ADDR_MASK: rdata_r <= {6'h00, compare_irq_enable_r, overflow_irq_enable_r};
            timer8_pkg::ADDR_FLAGS: rdata_r <= {6'h00, compare_match_flag_r, overflow_flag_r};
            timer8_pkg::ADDR_STATUS: rdata_r <= {4'h0, compare_output_state_r, bottom, top_max, dir_r};
            default: rdata_r <= timer8_pkg::BYTE_RESET;
         endcase
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   chk_stop_holds: assert property (
      timer_control_reg_r.clock_source_select == 3'h0 && !count_wr && !ctrl_wr |=> $stable(timer_count_value_r))
      else $error("counter moved while stopped");
   chk_cpu_write_wins: assert property (
      count_wr |=> timer_count_value_r == $past(bus_req.wdata))
      else $error("counter write lost");
   chk_flag_after_match: assert property (
      tick && match && !block_r |=> compare_match_flag_r)
      else $error("match did not set flag");
   chk_block_after_write: assert property (
      count_wr ##1 (tick && !compare_match_flag_r) |=> !compare_match_flag_r)
      else $error("match not blocked after counter write");
   chk_irq_follows_flag: assert property (
      compare_match_flag_r && compare_irq_enable_r |=> compare_irq_r)
      else $error("compare request missing");
   chk_flag_clear_write: assert property (
      flags_wr && bus_req.wdata[1] && !hit |=> !compare_match_flag_r)
      else $error("flag not cleared by write");
   chk_buffer_holds: assert property (
      pwm_mode && !ocr_load && !ctrl_wr |=> $stable(compare_value_r))
      else $error("active compare changed off top");
   chk_force_no_flag: assert property (
      force_act && !hit && !compare_match_flag_r |=> !compare_match_flag_r && $stable(timer_count_value_r) || $past(tick))
      else $error("force touched flag");
   chk_pin_override: assert property (
      act != 2'h0 && !ctrl_wr |=> pin_out_r == $past(compare_output_state_r))
      else $error("pin not driven by compare output");
   chk_action_none: assert property (
      act == 2'h0 && !ctrl_wr |=> $stable(compare_output_state_r))
      else $error("output changed with no action");
   chk_normal_overflow: assert property (
      mode == timer8_pkg::MODE_NORMAL && tick && top_max && !count_wr |=> overflow_flag_r && bottom)
      else $error("normal mode wrap missed overflow");
endmodule
`default_nettype wire

// ---- timer8_counter_compare_unit_tb_top.sv ----
// Purpose: self-checking bench for the 8-bit timer/compare block
// Assumes: single 20 MHz clock; register port driven right after rising edges
// Notes: every clock source is exercised; expected values come from small integer models
`timescale 1ns/1ps
`default_nettype none
module timer8_counter_compare_unit_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   timer8_pkg::bus_req_t bus_req = '0;
   logic [7:0] rdata_r;
   logic compare_irq_ack = 1'b0;
   logic overflow_irq_ack = 1'b0;
   logic compare_irq_r;
   logic overflow_irq_r;
   logic ext_tick_pin = 1'b0;
   logic port_out_value = 1'b0;
   logic compare_pin_direction = 1'b0;
   logic pin_out_r;
   logic pin_oe_r;
   int mismatches = 0;
   int num_checks = 0;
   int cycles = 0;
   int model_out;
   int r;
   logic [7:0] d;
   // acts per forced compare: 1 toggle, 3 set, 2 clear, as a force would apply them
   int acts[5] = '{1, 1, 3, 2, 3};
   // prescaler divisors of clock sources 2 to 5
   int divs[4] = '{8, 64, 256, 1024};

   timer8_counter_compare_unit timer8_counter_compare_unit_i (
      .clk(clk),
      .rst(rst),
      .bus_req(bus_req),
      .rdata_r(rdata_r),
      .compare_irq_ack(compare_irq_ack),
      .overflow_irq_ack(overflow_irq_ack),
      .compare_irq_r(compare_irq_r),
      .overflow_irq_r(overflow_irq_r),
      .ext_tick_pin(ext_tick_pin),
      .port_out_value(port_out_value),
      .compare_pin_direction(compare_pin_direction),
      .pin_out_r(pin_out_r),
      .pin_oe_r(pin_oe_r)
   );

   always #25 clk = ~clk;

   // ceiling well above the roughly 5000 cycles the tests need
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 12000)
      begin
         mismatches = mismatches + 1;
         wrap_up();
      end
   end

   function automatic logic [7:0] ctl(input int f, input int cs, input int act, input int mode);
      ctl = {f[0], cs[2:0], act[1:0], mode[1:0]};
   endfunction

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: v};
      @(posedge clk);
      bus_req <= '0;
   endtask

   // read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      bus_req <= '0;
      #1;
      v = rdata_r;
   endtask

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
      logic [7:0] v;
      rd(a, v);
      chk8(what, exp, v);
   endtask

   task automatic pulse_ack(input bit cmp);
      @(posedge clk);
      if (cmp)
         compare_irq_ack <= 1'b1;
      else
         overflow_irq_ack <= 1'b1;
      @(posedge clk);
      compare_irq_ack <= 1'b0;
      overflow_irq_ack <= 1'b0;
   endtask

   task automatic wrap_up();
      if (mismatches == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      void'($urandom(32'h8BBB));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      // reset state and register access while stopped
      rchk("ctrl", timer8_pkg::ADDR_CTRL, 8'h00);
      rchk("status", timer8_pkg::ADDR_STATUS, 8'h04);
      r = 1 + ($urandom % 254);
      wr(timer8_pkg::ADDR_COUNT, r[7:0]);
      rchk("count", timer8_pkg::ADDR_COUNT, r[7:0]);
      repeat (20) @(posedge clk);
      rchk("count", timer8_pkg::ADDR_COUNT, r[7:0]);
      wr(timer8_pkg::ADDR_COUNT, 8'hFF);
      rchk("status", timer8_pkg::ADDR_STATUS, 8'h02);
      rchk("unmapped", 3'h6, 8'h00);
      // blocked first match, then a full lap for flags and requests
      wr(timer8_pkg::ADDR_MASK, 8'h03);
      wr(timer8_pkg::ADDR_COMPARE, 8'h37);
      wr(timer8_pkg::ADDR_COUNT, 8'h37);
      wr(timer8_pkg::ADDR_FLAGS, 8'h03);
      wr(timer8_pkg::ADDR_CTRL, ctl(0, 1, 0, 0));
      repeat (4) @(posedge clk);
      rchk("flags", timer8_pkg::ADDR_FLAGS, 8'h00);
      repeat (260) @(posedge clk);
      wr(timer8_pkg::ADDR_CTRL, ctl(0, 0, 0, 0));
      rchk("flags", timer8_pkg::ADDR_FLAGS, 8'h03);
      chk1("compare_irq", 1'b1, compare_irq_r);
      chk1("overflow_irq", 1'b1, overflow_irq_r);
      // flag clearing by service and by writing one
      pulse_ack(1'b1);
      rchk("flags", timer8_pkg::ADDR_FLAGS, 8'h01);
      wr(timer8_pkg::ADDR_FLAGS, 8'h01);
      rchk("flags", timer8_pkg::ADDR_FLAGS, 8'h00);
      chk1("compare_irq", 1'b0, compare_irq_r);
      // pin sharing and forced compares in normal mode, then a no-action force written with the switch to fast PWM, timer stopped
      wr(timer8_pkg::ADDR_COUNT, 8'h40);
      port_out_value <= 1'($urandom);
      compare_pin_direction <= 1'b1;
      repeat (3) @(posedge clk);
      chk1("pin_out", port_out_value, pin_out_r);
      chk1("pin_oe", 1'b1, pin_oe_r);
      wr(timer8_pkg::ADDR_CTRL, ctl(1, 0, 0, 0));
      rchk("status", timer8_pkg::ADDR_STATUS, 8'h00);
      model_out = 0;
      foreach (acts[i])
      begin
         wr(timer8_pkg::ADDR_CTRL, ctl(1, 0, acts[i], 0));
         model_out = (acts[i] == 1) ? 1 - model_out : (acts[i] == 3 ? 1 : 0);
         rchk("status", timer8_pkg::ADDR_STATUS, {4'h0, model_out[0], 3'h0});
         chk1("pin_out", model_out[0], pin_out_r);
      end
      rchk("flags", timer8_pkg::ADDR_FLAGS, 8'h00);
      rchk("count", timer8_pkg::ADDR_COUNT, 8'h40);
      wr(timer8_pkg::ADDR_CTRL, ctl(1, 0, 0, 3));
      rchk("status", timer8_pkg::ADDR_STATUS, 8'h08);
      // compare write reaches the active value only outside the PWM modes
      for (int m = 0; m < 4; m++)
      begin
         wr(timer8_pkg::ADDR_CTRL, ctl(0, 0, 0, 0));
         wr(timer8_pkg::ADDR_COMPARE, 8'h37);
         wr(timer8_pkg::ADDR_CTRL, ctl(0, 0, 0, m));
         wr(timer8_pkg::ADDR_COMPARE, 8'h20);
         rchk("compare", timer8_pkg::ADDR_COMPARE, 8'h20);
         wr(timer8_pkg::ADDR_COUNT, 8'h1E);
         wr(timer8_pkg::ADDR_FLAGS, 8'h03);
         wr(timer8_pkg::ADDR_CTRL, ctl(0, 1, 0, m));
         repeat (8) @(posedge clk);
         wr(timer8_pkg::ADDR_CTRL, ctl(0, 0, 0, m));
         rd(timer8_pkg::ADDR_FLAGS, d);
         chk8("cmp_flag", (m == 0 || m == 2) ? 8'h02 : 8'h00, d & 8'h02);
         rd(timer8_pkg::ADDR_COUNT, d);
         chk1("count_moved", (m == 2) ? 1'b1 : 1'b0, d < 8'h1E);
      end
      // prescaler taps: 1024 clock edges between count write and read sample
      for (int cs = 2; cs < 6; cs++)
      begin
         wr(timer8_pkg::ADDR_CTRL, ctl(0, cs, 0, 0));
         wr(timer8_pkg::ADDR_COUNT, 8'h00);
         repeat (1023) @(posedge clk);
         rchk("presc_count", timer8_pkg::ADDR_COUNT, 8'(1024 / divs[cs - 2]));
      end
      // pin edges: three pulses, only one edge kind counts per source
      for (int cs = 6; cs < 8; cs++)
      begin
         wr(timer8_pkg::ADDR_CTRL, ctl(0, cs, 0, 0));
         wr(timer8_pkg::ADDR_COUNT, 8'h00);
         repeat (3)
         begin
            ext_tick_pin <= 1'b1;
            repeat (5) @(posedge clk);
            ext_tick_pin <= 1'b0;
            repeat (5) @(posedge clk);
         end
         rchk("pin_count", timer8_pkg::ADDR_COUNT, 8'h03);
      end
      // counter write beats the tick of the same edge
      wr(timer8_pkg::ADDR_CTRL, ctl(0, 1, 0, 0));
      wr(timer8_pkg::ADDR_COUNT, 8'h50);
      rchk("count", timer8_pkg::ADDR_COUNT, 8'h51);
      wr(timer8_pkg::ADDR_CTRL, ctl(0, 0, 0, 0));
      wrap_up();
   end
endmodule
`default_nettype wire

// ---- timer8_pkg.sv ----
// Purpose: shared constants and types of the 8-bit timer/compare block
// Assumes: 8-bit register port with a 3-bit word address
// Notes: mode enum order gives the waveform mode field encoding
`default_nettype none
package timer8_pkg;
   // register addresses
   localparam logic [2:0] ADDR_CTRL = 3'h0;
   localparam logic [2:0] ADDR_COUNT = 3'h1;
   localparam logic [2:0] ADDR_COMPARE = 3'h2;
   localparam logic [2:0] ADDR_MASK = 3'h3;
   localparam logic [2:0] ADDR_FLAGS = 3'h4;
   localparam logic [2:0] ADDR_STATUS = 3'h5;
   // bit positions in mask, flag and status registers
   localparam int BIT_OVF = 0;
   localparam int BIT_CMP = 1;
   localparam int STAT_DIR = 0;
   localparam int STAT_TOP = 1;
   localparam int STAT_BOTTOM = 2;
   localparam int STAT_OUT = 3;
   // counter limits and reset values
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [9:0] PRESC_RESET = 10'h000;
   // prescaler taps: tick when the low bits of the prescaler are zero
   localparam logic [9:0] PRESC_MASK_8 = 10'h007;
   localparam logic [9:0] PRESC_MASK_64 = 10'h03F;
   localparam logic [9:0] PRESC_MASK_256 = 10'h0FF;
   localparam logic [9:0] PRESC_MASK_1024 = 10'h3FF;
   // output action encodings
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR = 2'h2;
   localparam logic [1:0] ACT_SET = 2'h3;

   typedef enum logic [1:0] {MODE_NORMAL, MODE_PHASE_PWM, MODE_CTC, MODE_FAST_PWM} wave_mode_t;
   typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

   // control register layout, force strobe in the top bit
   typedef struct packed {
      logic force_compare_strobe;
      logic [2:0] clock_source_select;
      logic [1:0] output_action_bits;
      wave_mode_t waveform_mode_bits;
   } timer_control_t;

   typedef struct packed {
      logic we;
      logic re;
      logic [2:0] addr;
      logic [7:0] wdata;
   } bus_req_t;
endpackage
`default_nettype wire
